/* hw/aesb_engine.sv */
// Function
// - forward AES-128 single block encryption only, no decryption path
// - start task fetches key and cleartext by DMA before cipher runs
// - done event only after the ciphertext is fully written back
// - abort task stops the block and raises the abort event
// - conflict on shared core during cipher abandons it, abort event
// - operation is asynchronous, may not finish while core is taken
// - DMA master only reaches the data RAM window; code checks data_ptr at start only, write-back re-reads it unchecked
// - all memory accesses finished before either event is raised
// - key at offset 0, cleartext at 16, ciphertext written at 32
// - enable-set register, write 1 enables, read shows enables
// - one block takes about 6 microseconds
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`include "aesb_cfg.svh"
module aesb_engine
    import aesb_pkg::*;
#(
    parameter logic [31:0] RAM_BASE = 32'h2000_0000,
    parameter logic [31:0] RAM_SIZE = 32'h0001_0000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hclken,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    output logic dma_req,
    output logic dma_we,
    output logic [31:0] dma_addr,
    output logic [31:0] dma_wdata,
    input wire logic dma_ack,
    input wire logic [31:0] dma_rdata,
    input wire logic core_conflict,
    output logic core_req
);

// ----------------------------------------
// cipher arithmetic
// ----------------------------------------
function automatic logic [7:0] aesb_xtime(input logic [7:0] b);
    aesb_xtime = {b[6:0], 1'b0} ^ (b[7] ? 8'h1b : 8'h00);
endfunction : aesb_xtime
function automatic logic [7:0] aesb_gmul(input logic [7:0] a,
                                          input logic [7:0] b);
    logic [7:0] p, x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
        p = p ^ (b[i] ? x : 8'h00);
        x = aesb_xtime(x);
    end
    aesb_gmul = p;
endfunction : aesb_gmul
// inverse as x^254, then the affine map
function automatic logic [7:0] aesb_sbox(input logic [7:0] b);
    logic [7:0] p, r;
    p = b;
    r = 8'h01;
    for (int i = 1; i < 8; i++) begin
        p = aesb_gmul(p, p);
        r = aesb_gmul(r, p);
    end
    aesb_sbox = r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]}
        ^ {r[4:0], r[7:5]} ^ {r[3:0], r[7:4]} ^ 8'h63;
endfunction : aesb_sbox
// next round key from current key and round constant
function automatic logic [127:0] aesb_kexp(input logic [127:0] k,
                                            input logic [7:0] rc);
    logic [31:0] t;
    t = {aesb_sbox(k[23:16]) ^ rc, aesb_sbox(k[15:8]),
         aesb_sbox(k[7:0]), aesb_sbox(k[31:24])};
    aesb_kexp[127:96] = k[127:96] ^ t;
    aesb_kexp[95:64] = k[95:64] ^ aesb_kexp[127:96];
    aesb_kexp[63:32] = k[63:32] ^ aesb_kexp[95:64];
    aesb_kexp[31:0] = k[31:0] ^ aesb_kexp[63:32];
endfunction : aesb_kexp
// one encryption round; byte 0 sits in the top bits
function automatic logic [127:0] aesb_round(input logic [127:0] s,
                                             input logic [127:0] rk,
                                             input logic last);
    logic [7:0] b [16], m [16];
    for (int c = 0; c < 4; c++) begin
        for (int r = 0; r < 4; r++) begin
            b[4*c+r] = aesb_sbox(s[127-8*(4*((c+r)%4)+r) -: 8]);
        end
    end
    for (int c = 0; c < 4; c++) begin
        for (int r = 0; r < 4; r++) begin
            m[4*c+r] = last ? b[4*c+r] :
                aesb_xtime(b[4*c+r]) ^ aesb_xtime(b[4*c+(r+1)%4])
                ^ b[4*c+(r+1)%4] ^ b[4*c+(r+2)%4] ^ b[4*c+(r+3)%4];
        end
    end
    for (int i = 0; i < 16; i++) begin
        aesb_round[127-8*i -: 8] = rk[127-8*i -: 8] ^ m[i];
    end
endfunction : aesb_round
// memory word w of a block, little endian bytes
function automatic logic [31:0] aesb_getw(input logic [127:0] v,
                                           input logic [1:0] w);
    aesb_getw = 32'h0000_0000;
    for (int j = 0; j < 4; j++) begin
        aesb_getw[8*j +: 8] = v[127-8*(4*w+j) -: 8];
    end
endfunction : aesb_getw
function automatic logic [127:0] aesb_putw(input logic [127:0] v,
                                            input logic [1:0] w,
                                            input logic [31:0] d);
    aesb_putw = v;
    for (int j = 0; j < 4; j++) begin
        aesb_putw[127-8*(4*w+j) -: 8] = d[8*j +: 8];
    end
endfunction : aesb_putw

// ----------------------------------------
// bus slave
// ----------------------------------------
logic wr_pend;
logic [11:0] wr_addr;
logic done_ev, err_ev;
logic [1:0] irq_en;
logic [31:0] data_ptr;
logic done_set, err_set;
aesb_state_t state;
logic start_trig, abort_trig, bus_sel;

assign bus_sel = hsel && htrans[1] && hready;
assign start_trig = wr_pend && (wr_addr == `AESB_START_OFS)
    && hwdata[`AESB_TRIG_BIT];
assign abort_trig = wr_pend && (wr_addr == `AESB_ABORT_OFS)
    && hwdata[`AESB_TRIG_BIT];

// address phase capture, zero wait, always okay
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_pend <= 1'b0;
        wr_addr <= 12'h000;
        hrdata <= 32'h0000_0000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end else if (hclken) begin
        wr_pend <= bus_sel && hwrite;
        wr_addr <= haddr[11:0];
        hrdata <= 32'h0000_0000;
        if (bus_sel && !hwrite) begin
            unique case (haddr[11:0])
                `AESB_DONE_OFS: hrdata <= {31'h0, done_ev};
                `AESB_ERR_OFS: hrdata <= {31'h0, err_ev};
                `AESB_IENSET_OFS: hrdata <= {30'h0, irq_en};
                `AESB_IENCLR_OFS: hrdata <= {30'h0, irq_en};
                `AESB_PTR_OFS: hrdata <= data_ptr;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end
end

// pointer register
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        data_ptr <= `AESB_PTR_RST;
    end else if (hclken && wr_pend && wr_addr == `AESB_PTR_OFS) begin
        data_ptr <= hwdata;
    end
end

// ----------------------------------------
// events and interrupt
// ----------------------------------------
// sticky events, hardware set beats write; level irq from them
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        done_ev <= 1'b0;
        err_ev <= 1'b0;
        irq <= 1'b0;
    end else if (hclken) begin
        irq <= (done_ev && irq_en[`AESB_IRQ_DONE_BIT])
            || (err_ev && irq_en[`AESB_IRQ_ERR_BIT]);
        if (done_set) begin
            done_ev <= 1'b1;
        end else if (wr_pend && wr_addr == `AESB_DONE_OFS) begin
            done_ev <= hwdata[0];
        end
        if (err_set) begin
            err_ev <= 1'b1;
        end else if (wr_pend && wr_addr == `AESB_ERR_OFS) begin
            err_ev <= hwdata[0];
        end
    end
end

// enables: set and clear registers share one state
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        irq_en <= `AESB_IEN_RST;
    end else if (hclken && wr_pend) begin
        if (wr_addr == `AESB_IENSET_OFS) begin
            irq_en <= irq_en | hwdata[1:0];
        end else if (wr_addr == `AESB_IENCLR_OFS) begin
            irq_en <= irq_en & ~hwdata[1:0];
        end
    end
end

// ----------------------------------------
// engine sequence and DMA master
// ----------------------------------------
logic [2:0] idx;
logic [3:0] round;
logic [7:0] pace, rcon;
logic [127:0] blk, key, next_key;
logic abort_pend, ptr_ok;

assign ptr_ok = (data_ptr[1:0] == 2'b00) && (data_ptr >= RAM_BASE)
    && (data_ptr - RAM_BASE <= RAM_SIZE - `AESB_STRUCT_BYTES);
assign next_key = aesb_kexp(key, rcon);

always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        state <= AESB_IDLE;
        idx <= 3'h0;
        round <= 4'h0;
        pace <= 8'h00;
        rcon <= 8'h01;
        blk <= '0;
        key <= '0;
        abort_pend <= 1'b0;
        dma_req <= 1'b0;
        dma_we <= 1'b0;
        dma_addr <= 32'h0000_0000;
        dma_wdata <= 32'h0000_0000;
        core_req <= 1'b0;
        done_set <= 1'b0;
        err_set <= 1'b0;
    end else if (hclken) begin
        done_set <= 1'b0;
        err_set <= 1'b0;
        unique case (state)
            AESB_IDLE: begin
                if (start_trig && !ptr_ok) begin
                    err_set <= 1'b1;
                end else if (start_trig) begin
                    state <= AESB_READ;
                    idx <= 3'h0;
                    abort_pend <= 1'b0;
                    dma_req <= 1'b1;
                    dma_we <= 1'b0;
                    dma_addr <= data_ptr + `AESB_KEY_OFS;
                end
            end
            AESB_READ: begin
                abort_pend <= abort_pend || abort_trig;
                if (dma_ack) begin
                    if (idx[2]) begin
                        blk <= aesb_putw(blk, idx[1:0], dma_rdata);
                    end else begin
                        key <= aesb_putw(key, idx[1:0], dma_rdata);
                    end
                    if (abort_pend || abort_trig) begin
                        dma_req <= 1'b0;
                        err_set <= 1'b1;
                        state <= AESB_IDLE;
                    end else if (idx == 3'h7) begin
                        // initial key addition
                        blk <= aesb_putw(blk, 2'h3, dma_rdata) ^ key;
                        dma_req <= 1'b0;
                        core_req <= 1'b1;
                        round <= 4'h1;
                        pace <= 8'h00;
                        rcon <= 8'h01;
                        state <= AESB_CIPH;
                    end else begin
                        idx <= idx + 3'h1;
                        dma_addr <= dma_addr + 32'h0000_0004;
                    end
                end
            end
            AESB_CIPH: begin
                if (abort_trig || core_conflict) begin
                    core_req <= 1'b0;
                    err_set <= 1'b1;
                    state <= AESB_IDLE;
                end else if (pace != 8'(`AESB_STEP_CYC - 1)) begin
                    pace <= pace + 8'h01;
                end else begin
                    pace <= 8'h00;
                    blk <= aesb_round(blk, next_key,
                        round == 4'(`AESB_ROUNDS));
                    key <= next_key;
                    rcon <= aesb_xtime(rcon);
                    round <= round + 4'h1;
                    if (round == 4'(`AESB_ROUNDS)) begin
                        core_req <= 1'b0;
                        idx <= 3'h0;
                        dma_req <= 1'b1;
                        dma_we <= 1'b1;
                        dma_addr <= data_ptr + `AESB_CIPH_OFS;
                        dma_wdata <= aesb_getw(aesb_round(blk,
                            next_key, 1'b1), 2'h0);
                        state <= AESB_WRITE;
                    end
                end
            end
            AESB_WRITE: begin
                abort_pend <= abort_pend || abort_trig;
                if (dma_ack) begin
                    if (abort_pend || abort_trig) begin
                        dma_req <= 1'b0;
                        err_set <= 1'b1;
                        state <= AESB_IDLE;
                    end else if (idx == 3'h3) begin
                        dma_req <= 1'b0;
                        done_set <= 1'b1;
                        state <= AESB_IDLE;
                    end else begin
                        idx <= idx + 3'h1;
                        dma_addr <= dma_addr + 32'h0000_0004;
                        dma_wdata <= aesb_getw(blk, idx[1:0] + 2'h1);
                    end
                end
            end
            default: state <= AESB_IDLE;
        endcase
    end
end

endmodule : aesb_engine

/* hw/aesb_cfg.svh */
`ifndef AESB_CFG_SVH
`define AESB_CFG_SVH
// register offsets
`define AESB_START_OFS 12'h000
`define AESB_ABORT_OFS 12'h004
`define AESB_DONE_OFS 12'h100
`define AESB_ERR_OFS 12'h104
`define AESB_IENSET_OFS 12'h304
`define AESB_IENCLR_OFS 12'h308
`define AESB_PTR_OFS 12'h504
// field positions
`define AESB_TRIG_BIT 0
`define AESB_IRQ_DONE_BIT 0
`define AESB_IRQ_ERR_BIT 1
// reset values
`define AESB_PTR_RST 32'h0000_0000
`define AESB_IEN_RST 2'h0
// data structure layout, byte offsets from the pointer
`define AESB_KEY_OFS 32'h0000_0000
`define AESB_CLR_OFS 32'h0000_0010
`define AESB_CIPH_OFS 32'h0000_0020
`define AESB_STRUCT_BYTES 32'h0000_0030
// timing
`define AESB_CLK_NS 40
`define AESB_RUN_NS 6000
`define AESB_RUN_CYC (`AESB_RUN_NS / `AESB_CLK_NS)
`define AESB_ROUNDS 10
`define AESB_STEP_CYC (`AESB_RUN_CYC / `AESB_ROUNDS)
`endif

/* hw/aesb_pkg.sv */
package aesb_pkg;
    // engine sequence
    typedef enum logic [2:0] {
        AESB_IDLE, AESB_READ, AESB_CIPH, AESB_WRITE
    } aesb_state_t;
endpackage : aesb_pkg

/* sim/aesb_engine_chk.sv */
`timescale 1ns/1ps
module aesb_engine_chk #(
    parameter logic [31:0] RAM_BASE = 32'h2000_0000,
    parameter logic [31:0] RAM_SIZE = 32'h0001_0000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hclken,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic irq,
    input wire logic dma_req,
    input wire logic dma_we,
    input wire logic [31:0] dma_addr,
    input wire logic [31:0] dma_wdata,
    input wire logic dma_ack,
    input wire logic [31:0] dma_rdata,
    input wire logic core_conflict,
    input wire logic core_req
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // bus write taken in its address phase
    logic wr_taken;
    assign wr_taken = hclken && hsel && htrans[1] && hwrite && hready;

    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait okay");
    dma_hold_a: assert property (dma_req && !dma_ack |=> dma_req
        && $stable(dma_addr) && $stable(dma_we) && $stable(dma_wdata))
        else $error("dma request changed before ack");
    dma_window_a: assert property (dma_req |-> dma_addr >= RAM_BASE
        && dma_addr < RAM_BASE + RAM_SIZE && dma_addr[1:0] == 2'b00)
        else $error("dma access outside data ram");
    dma_step_a: assert property (dma_req && dma_ack |=> !dma_req
        || dma_addr == $past(dma_addr) + 32'h0000_0004)
        else $error("dma address not sequential");
    fetch_first_a: assert property ($rose(core_req) |-> !dma_req
        && $past(dma_ack) && !$past(dma_we))
        else $error("cipher started before fetch done");
    write_late_a: assert property (dma_req && dma_we && !$past(dma_req)
        |-> $past(core_req))
        else $error("write back without cipher");
    conflict_drop_a: assert property (core_req && !dma_req
        && core_conflict |=> !core_req || (dma_req && dma_we))
        else $error("core kept after conflict");
    irq_fall_a: assert property ($fell(irq) |-> $past(wr_taken, 3))
        else $error("irq dropped without a bus write");
endmodule : aesb_engine_chk

/* sim/aesb_ram_model.sv */
`timescale 1ns/1ps
module aesb_ram_model #(
    parameter logic [31:0] BASE = 32'h2000_0000,
    parameter logic [31:0] SIZE = 32'h0000_0100
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic dma_req,
    input wire logic dma_we,
    input wire logic [31:0] dma_addr,
    input wire logic [31:0] dma_wdata,
    input wire logic [3:0] lat,
    output logic dma_ack,
    output logic [31:0] dma_rdata
);
    logic [31:0] mem [64];
    logic [31:0] n_acc;
    logic [3:0] wait_cnt;
    logic stray;
    logic [5:0] idx;
    assign idx = 6'((dma_addr - BASE) >> 2);
    // one-cycle ack after lat idle cycles, data scrambled when idle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dma_ack <= 1'b0;
            dma_rdata <= 32'h0000_0000;
            wait_cnt <= 4'h0;
            n_acc <= 32'h0000_0000;
        end else if (dma_req && !dma_ack && wait_cnt >= lat) begin
            dma_ack <= 1'b1;
            wait_cnt <= 4'h0;
            n_acc <= n_acc + 32'h0000_0001;
            dma_rdata <= mem[idx];
            if (dma_we) mem[idx] <= dma_wdata;
        end else begin
            dma_ack <= 1'b0;
            dma_rdata <= ~dma_rdata;
            if (dma_req && !dma_ack) wait_cnt <= wait_cnt + 4'h1;
        end
    end
    // sticky flag for any access outside the ram window
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) stray <= 1'b0;
        else if (dma_req && (dma_addr < BASE || dma_addr >= BASE + SIZE))
            stray <= 1'b1;
    end
endmodule : aesb_ram_model

/* sim/tb_top.sv */
`timescale 1ns/1ps
`include "aesb_cfg.svh"
module tb_top;
    localparam logic [31:0] BASE = 32'h2000_0000;
    localparam logic [31:0] SIZE = 32'h0000_0100;
    localparam logic [31:0] PTR = 32'h2000_0040;
    localparam logic [31:0] POISON = 32'hdead_beef;
    localparam logic [31:0] IN_W [8] = '{32'h0302_0100, 32'h0706_0504,
        32'h0b0a_0908, 32'h0f0e_0d0c, 32'h3322_1100, 32'h7766_5544,
        32'hbbaa_9988, 32'hffee_ddcc};
    localparam logic [31:0] CT_W [4] = '{32'hd8e0_c469, 32'h3004_7b6a,
        32'h80b7_cdd8, 32'h5ac5_b470};
    logic hclk, hresetn, hclken, hsel, hwrite, core_conflict;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata;
    logic [3:0] lat;
    wire logic hreadyout, hresp, irq, dma_req, dma_we, dma_ack, core_req;
    wire logic [31:0] hrdata, dma_addr, dma_wdata, dma_rdata;
    int num_errors, comparisons;

    aesb_engine #(.RAM_BASE(BASE), .RAM_SIZE(SIZE)) uut (.hclk, .hresetn,
        .hclken, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq,
        .dma_req, .dma_we, .dma_addr, .dma_wdata, .dma_ack, .dma_rdata,
        .core_conflict, .core_req);
    aesb_ram_model #(.BASE(BASE), .SIZE(SIZE)) ram (.hclk, .hresetn,
        .dma_req, .dma_we, .dma_addr, .dma_wdata, .lat, .dma_ack,
        .dma_rdata);

    // free-running bus clock
    always #20 hclk = ~hclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic ahb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h0_0000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : ahb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0000_0000, q);
        chk(q, e, "register read");
    endtask : rd_chk

    task automatic go(input logic [31:0] p, input logic [31:0] en);
        for (int i = 0; i < 8; i++) ram.mem[16 + i] = IN_W[i];
        for (int i = 0; i < 4; i++) ram.mem[24 + i] = POISON;
        wr(`AESB_DONE_OFS, 32'h0000_0000);
        wr(`AESB_ERR_OFS, 32'h0000_0000);
        wr(`AESB_IENCLR_OFS, 32'h0000_0003);
        wr(`AESB_IENSET_OFS, en);
        wr(`AESB_PTR_OFS, p);
        wr(`AESB_START_OFS, 32'h0000_0001);
    endtask : go

    task automatic wait_irq(output int n);
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin
            @(posedge hclk);
            n++;
        end
        chk(32'(irq), 32'h0000_0001, "irq raised");
    endtask : wait_irq

    task automatic t_regs;
        rd_chk(`AESB_PTR_OFS, `AESB_PTR_RST);
        rd_chk(`AESB_IENSET_OFS, 32'h0000_0000);
        wr(`AESB_IENSET_OFS, 32'h0000_0003);
        wr(`AESB_IENSET_OFS, 32'h0000_0000);
        rd_chk(`AESB_IENSET_OFS, 32'h0000_0003);
        wr(`AESB_IENCLR_OFS, 32'h0000_0001);
        rd_chk(`AESB_IENCLR_OFS, 32'h0000_0002);
        wr(`AESB_IENCLR_OFS, 32'h0000_0002);
        rd_chk(`AESB_IENSET_OFS, 32'h0000_0000);
        wr(12'h200, 32'hffff_ffff);
        rd_chk(12'h200, 32'h0000_0000);
        $display("register test done");
    endtask : t_regs

    task automatic t_enc(input logic [3:0] l, input int f);
        int n;
        lat <= l;
        go(PTR, 32'h0000_0001);
        repeat (40) @(posedge hclk);
        // freeze mid cipher: the block must pick up where it stopped
        if (f > 0) begin
            hclken <= 1'b0;
            repeat (f) @(posedge hclk);
            chk(32'(core_req & ~irq), 32'h0000_0001, "frozen");
            hclken <= 1'b1;
        end
        wait_irq(n);
        chk(32'(n > 100 && n < 360 + f), 32'h0000_0001, "run time");
        chk(32'(dma_req), 32'h0000_0000, "dma idle");
        for (int i = 0; i < 4; i++)
            chk(ram.mem[24 + i], CT_W[i], "ciphertext");
        for (int i = 0; i < 8; i++)
            chk(ram.mem[16 + i], IN_W[i], "input kept");
        rd_chk(`AESB_DONE_OFS, 32'h0000_0001);
        rd_chk(`AESB_ERR_OFS, 32'h0000_0000);
        wr(`AESB_DONE_OFS, 32'h0000_0000);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h0000_0000, "irq cleared");
        rd_chk(`AESB_DONE_OFS, 32'h0000_0000);
        $display("encrypt test done, latency %0d", l);
    endtask : t_enc

    task automatic t_stop(input int d, input logic by_core);
        int n;
        lat <= 4'h0;
        go(PTR, 32'h0000_0002);
        repeat (d) @(posedge hclk);
        if (by_core) begin
            core_conflict <= 1'b1;
            @(posedge hclk);
            core_conflict <= 1'b0;
        end else wr(`AESB_ABORT_OFS, 32'h0000_0001);
        wait_irq(n);
        chk(32'(dma_req | core_req), 32'h0000_0000, "idle");
        rd_chk(`AESB_ERR_OFS, 32'h0000_0001);
        rd_chk(`AESB_DONE_OFS, 32'h0000_0000);
        chk(ram.mem[24], POISON, "no write back");
        $display("abort test done, delay %0d", d);
    endtask : t_stop

    task automatic t_bad;
        int n;
        logic [31:0] acc;
        acc = ram.n_acc;
        go(BASE + SIZE - 32'h0000_0020, 32'h0000_0002);
        wait_irq(n);
        rd_chk(`AESB_ERR_OFS, 32'h0000_0001);
        chk(ram.n_acc, acc, "no access");
        chk(32'(ram.stray), 32'h0000_0000, "stray access");
        $display("bad pointer test done");
    endtask : t_bad

    task automatic wrap_up;
        $display("checks %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hclken = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        core_conflict = 1'b0;
        lat = 4'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs;
        t_enc(4'h0, 0);
        t_enc(4'h3, 0);
        t_stop(1, 1'b0);
        t_stop(60, 1'b0);
        t_stop(60, 1'b1);
        t_bad;
        t_enc(4'h0, 150);
        wrap_up;
    end

    // watchdog against a hung wait
    initial begin
        repeat (20000) @(posedge hclk);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up;
    end
endmodule : tb_top

bind aesb_engine aesb_engine_chk #(.RAM_BASE(RAM_BASE),
    .RAM_SIZE(RAM_SIZE)) chk (.hclk, .hresetn, .hclken, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .irq, .dma_req, .dma_we, .dma_addr, .dma_wdata, .dma_ack,
    .dma_rdata, .core_conflict, .core_req);
